/* logic/tcsr_pkg.sv */
package tcsr_pkg;

  // ----------------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------------
  localparam logic [11:0] TCSR_SETUP_OFS = 12'h000;
  localparam logic [11:0] TCSR_CMD_OFS = 12'h004;
  localparam logic [11:0] TCSR_STATUS_OFS = 12'h008;
  localparam logic [31:0] TCSR_SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] TCSR_SETUP_WMASK = 32'h3F03_6FFB;
  localparam int TCSR_CMD_START_BIT = 0;
  localparam int TCSR_CMD_STOP_BIT = 1;
  localparam int TCSR_ST_RUN_BIT = 0;
  localparam int TCSR_ST_DIR_BIT = 1;
  localparam int TCSR_ST_TOPBV_BIT = 2;
  localparam int TCSR_ST_BV_LSB = 8;
  localparam int TCSR_ST_ICV_LSB = 16;
  localparam int TCSR_ST_POL_LSB = 24;
  localparam logic [3:0] TCSR_DIV_MAX = 4'hA;
  localparam int TCSR_DIV_W = 10;
  localparam int TCSR_CHANNELS = 4;
  localparam logic [1:0] TCSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCSR_RESP_SLVERR = 2'h2;
  localparam logic [4:0] TCSR_PIN_RESET = 5'h00;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TCSR_ACT_NONE = 2'h0,
    TCSR_ACT_START = 2'h1,
    TCSR_ACT_STOP = 2'h2,
    TCSR_ACT_RELOAD_THEN_RUN = 2'h3
  } tcsr_action_e;

  localparam logic [1:0] TCSR_SRC_DIVIDED = 2'h0;
  localparam logic [1:0] TCSR_SRC_CHANNEL1_INPUT = 2'h1;
  localparam logic [1:0] TCSR_SRC_NEIGHBOUR_WRAP = 2'h2;
  localparam logic [1:0] TCSR_MODE_UP = 2'h0;
  localparam logic [1:0] TCSR_MODE_QUAD = 2'h3;
  localparam logic [1:0] TCSR_FN_OFF = 2'h0;
  localparam logic [1:0] TCSR_FN_CAPTURE = 2'h1;
  localparam logic [1:0] TCSR_FN_COMPARE = 2'h2;
  localparam logic [1:0] TCSR_FN_PWM = 2'h3;

  typedef enum logic [1:0] {
    TCSR_IDLE = 2'b01,
    TCSR_RUN = 2'b10
  } tcsr_run_e;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsvd_31_30;
    logic reload_sets_initial;
    logic always_track;
    logic [3:0] clock_divide_select;
    logic [5:0] rsvd_23_18;
    logic [1:0] count_clock_source;
    logic rsvd_15;
    logic peer_command_out_block;
    logic double_count;
    logic rsvd_12;
    tcsr_action_e falling_edge_action;
    tcsr_action_e rising_edge_action;
    logic dma_req_clear_on_channel_active;
    logic run_during_halt;
    logic quad_resolution_select;
    logic single_pass_enable;
    logic peer_command_follow;
    logic rsvd_2;
    logic [1:0] count_mode;
  } tcsr_setup_s;

  typedef struct packed {
    logic reload;
    logic stop;
    logic start;
  } tcsr_peer_s;

endpackage

/* logic/tcsr_timer_control_status_regs.sv */
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module tcsr_timer_control_status_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register slave
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Asynchronous pins
  input wire logic timer_input,
  input wire logic [3:0] chan_input,
  // Neighbouring timers
  input wire logic neighbour_wrap_clock,
  input wire tcsr_pkg::tcsr_peer_s peer_in,
  output tcsr_pkg::tcsr_peer_s peer_out,
  // Counter datapath
  input wire logic quad_count_tick,
  input wire logic counter_wrap,
  input wire logic count_dir,
  input wire logic top_buffer_valid,
  output logic count_step,
  output logic count_reload,
  output logic timer_running,
  output logic quad_resolution_x4,
  output tcsr_pkg::tcsr_setup_s setup_out,
  // Channel datapath
  input wire logic [3:0][1:0] channel_function_select,
  input wire logic [3:0] chan_mode_off_write,
  input wire logic [3:0] capture_event,
  input wire logic [3:0] capture_edge_falling,
  input wire logic [3:0] capture_queue_nonempty,
  input wire logic [3:0] chan_buffer_pending,
  // Debug and DMA
  input wire logic cpu_debug_halt,
  input wire logic dma_channel_active,
  output logic dma_req_clear
);
  import tcsr_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  tcsr_setup_s setup;
  tcsr_run_e run_state;
  tcsr_run_e next_run_state;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;
  logic [TCSR_DIV_W-1:0] div_cnt;
  logic [TCSR_DIV_W-1:0] div_mask;
  logic [TCSR_DIV_W:0] div_onehot;
  logic [3:0] div_code;
  logic divided_tick;
  logic src_tick;
  logic frozen;
  logic timer_rise;
  logic timer_fall;
  logic ch1_rise;
  tcsr_peer_s sw_cmd;
  tcsr_peer_s edge_cmd;
  tcsr_peer_s own_cmd;
  tcsr_peer_s all_cmd;
  logic [3:0] pol;
  logic [3:0] icv;
  logic [3:0] bufv;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic [31:0] next_setup;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_hit;

  function automatic tcsr_peer_s act_decode(input tcsr_action_e act);
    tcsr_peer_s c;
    c = '0;
    case (act)
      TCSR_ACT_START: c.start = 1'b1;
      TCSR_ACT_STOP: c.stop = 1'b1;
      TCSR_ACT_RELOAD_THEN_RUN: begin
        c.reload = 1'b1;
        c.start = 1'b1;
      end
      default: c = '0;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= TCSR_PIN_RESET;
      pin_sync <= TCSR_PIN_RESET;
      pin_prev <= TCSR_PIN_RESET;
    end else begin
      pin_meta <= {chan_input, timer_input};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign timer_rise = pin_sync[0] & ~pin_prev[0];
  assign timer_fall = ~pin_sync[0] & pin_prev[0];
  assign ch1_rise = pin_sync[2] & ~pin_prev[2];

  // ----------------------------------------------------------------------
  // Prescaler and count clock selection
  // ----------------------------------------------------------------------
  // Codes above the largest divider are clamped rather than wrapped, so a
  // stray code cannot speed the counter up.
  assign div_code = (setup.clock_divide_select > TCSR_DIV_MAX) ?
                    TCSR_DIV_MAX : setup.clock_divide_select;
  assign div_onehot = (TCSR_DIV_W+1)'(1) << div_code;
  assign div_mask = div_onehot[TCSR_DIV_W-1:0] - TCSR_DIV_W'(1);
  assign divided_tick = (div_cnt & div_mask) == div_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + TCSR_DIV_W'(1);
    end
  end

  always_comb begin
    src_tick = 1'b0;
    if (setup.count_mode == TCSR_MODE_QUAD) begin
      src_tick = quad_count_tick;
    end else begin
      case (setup.count_clock_source)
        TCSR_SRC_DIVIDED: src_tick = divided_tick;
        TCSR_SRC_CHANNEL1_INPUT: src_tick = ch1_rise;
        TCSR_SRC_NEIGHBOUR_WRAP: src_tick = neighbour_wrap_clock;
        default: src_tick = 1'b0;
      endcase
    end
  end

  assign frozen = cpu_debug_halt & ~setup.run_during_halt;

  // ----------------------------------------------------------------------
  // Start, stop and reload commands
  // ----------------------------------------------------------------------
  always_comb begin
    sw_cmd = '0;
    if (wr_fire && aw_addr_q == TCSR_CMD_OFS && w_strb_q[0]) begin
      sw_cmd.start = w_data_q[TCSR_CMD_START_BIT];
      sw_cmd.stop = w_data_q[TCSR_CMD_STOP_BIT];
    end
  end

  always_comb begin
    edge_cmd = '0;
    if (timer_fall) begin
      edge_cmd = act_decode(setup.falling_edge_action);
    end else if (timer_rise) begin
      edge_cmd = act_decode(setup.rising_edge_action);
    end
  end

  assign own_cmd = sw_cmd | edge_cmd;
  // Commands taken from peers are not sent on, so a ring of timers that
  // follow each other cannot circulate a command forever.
  assign all_cmd = own_cmd | (setup.peer_command_follow ? peer_in : '0);

  // Stop wins over start when both arrive together; a start beats the
  // single-pass stop so a restart at the wrap is not lost.
  always_comb begin
    next_run_state = run_state;
    case (run_state)
      TCSR_IDLE: begin
        if (all_cmd.start && !all_cmd.stop) begin
          next_run_state = TCSR_RUN;
        end
      end
      TCSR_RUN: begin
        if (all_cmd.stop) begin
          next_run_state = TCSR_IDLE;
        end else if (all_cmd.start) begin
          next_run_state = TCSR_RUN;
        end else if (counter_wrap && setup.single_pass_enable) begin
          next_run_state = TCSR_IDLE;
        end
      end
      default: next_run_state = TCSR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_state <= TCSR_IDLE;
    end else begin
      run_state <= next_run_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_step <= 1'b0;
      count_reload <= 1'b0;
      peer_out <= '0;
      dma_req_clear <= 1'b0;
    end else begin
      count_step <= (run_state == TCSR_RUN) && !frozen && src_tick;
      count_reload <= all_cmd.reload;
      peer_out <= setup.peer_command_out_block ? '0 : own_cmd;
      dma_req_clear <= setup.dma_req_clear_on_channel_active &
                       dma_channel_active;
    end
  end

  assign timer_running = (run_state == TCSR_RUN);
  assign quad_resolution_x4 = setup.quad_resolution_select;
  assign setup_out = setup;

  // ----------------------------------------------------------------------
  // Per-channel status
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < TCSR_CHANNELS; i++) begin : g_chan
    logic is_cap;
    logic is_cmp;
    assign is_cap = channel_function_select[i] == TCSR_FN_CAPTURE;
    assign is_cmp = channel_function_select[i] == TCSR_FN_COMPARE ||
                    channel_function_select[i] == TCSR_FN_PWM;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pol[i] <= 1'b0;
      end else if (is_cap && capture_event[i]) begin
        pol[i] <= capture_edge_falling[i];
      end else if (chan_mode_off_write[i]) begin
        pol[i] <= 1'b0;
      end else if (is_cmp || (setup.always_track && is_cap)) begin
        pol[i] <= pin_sync[i+1];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        icv[i] <= 1'b0;
        bufv[i] <= 1'b0;
      end else begin
        icv[i] <= is_cap && capture_queue_nonempty[i] &&
                  !chan_mode_off_write[i];
        bufv[i] <= is_cmp && chan_buffer_pending[i] &&
                   !chan_mode_off_write[i];
      end
    end
  end

  always_comb begin
    status_word = '0;
    status_word[TCSR_ST_POL_LSB +: TCSR_CHANNELS] = pol;
    status_word[TCSR_ST_ICV_LSB +: TCSR_CHANNELS] = icv;
    status_word[TCSR_ST_BV_LSB +: TCSR_CHANNELS] = bufv;
    status_word[TCSR_ST_TOPBV_BIT] = top_buffer_valid;
    status_word[TCSR_ST_DIR_BIT] = count_dir;
    status_word[TCSR_ST_RUN_BIT] = timer_running;
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= {awaddr[11:2], 2'b00};
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_comb begin
    next_setup = setup;
    for (int b = 0; b < 4; b++) begin
      if (w_strb_q[b]) begin
        next_setup[b*8 +: 8] = w_data_q[b*8 +: 8];
      end
    end
    next_setup = next_setup & TCSR_SETUP_WMASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup <= tcsr_setup_s'(TCSR_SETUP_RESET);
      bvalid <= 1'b0;
      bresp <= TCSR_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        if (aw_addr_q == TCSR_SETUP_OFS) begin
          setup <= tcsr_setup_s'(next_setup);
        end
        bvalid <= 1'b1;
        bresp <= (aw_addr_q == TCSR_SETUP_OFS ||
                  aw_addr_q == TCSR_CMD_OFS ||
                  aw_addr_q == TCSR_STATUS_OFS) ?
                 TCSR_RESP_OKAY : TCSR_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  assign arready = !rvalid;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case ({araddr[11:2], 2'b00})
      TCSR_SETUP_OFS: rd_word = setup;
      TCSR_CMD_OFS: rd_word = '0;
      TCSR_STATUS_OFS: rd_word = status_word;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= TCSR_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? TCSR_RESP_OKAY : TCSR_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

/* tb/tcsr_monitor.sv */
`timescale 1ns/1ps
module tcsr_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic neighbour_wrap_clock,
  input wire logic quad_count_tick,
  input wire logic count_step,
  input wire logic count_reload,
  input wire logic timer_running,
  input wire logic quad_resolution_x4,
  input wire logic cpu_debug_halt,
  input wire logic dma_channel_active,
  input wire logic dma_req_clear,
  input wire tcsr_pkg::tcsr_peer_s peer_in,
  input wire tcsr_pkg::tcsr_peer_s peer_out,
  input wire tcsr_pkg::tcsr_setup_s setup_out
);
  import tcsr_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_dma_clear: assert property (
    dma_req_clear == $past(setup_out.dma_req_clear_on_channel_active
    && dma_channel_active))
    else $error("dma clear does not follow enable and channel");
  a_peer_block: assert property (
    setup_out.peer_command_out_block |=> peer_out == 3'h0)
    else $error("peer command sent while blocked");
  a_halt_freeze: assert property (
    cpu_debug_halt && !setup_out.run_during_halt |=> !count_step)
    else $error("counter stepped during debug halt");
  a_quad_res: assert property (
    quad_resolution_x4 == setup_out.quad_resolution_select)
    else $error("quadrature resolution mismatch");
  a_peer_stop: assert property (
    peer_in.stop && setup_out.peer_command_follow |=> !timer_running)
    else $error("peer stop ignored");
  a_peer_reload: assert property (
    peer_in.reload && !peer_in.stop && setup_out.peer_command_follow
    |=> count_reload)
    else $error("peer reload ignored");
  a_quad_gate: assert property (
    setup_out.count_mode == TCSR_MODE_QUAD && !quad_count_tick
    |=> !count_step)
    else $error("step without decoder tick");
  a_wrap_step: assert property (
    timer_running && !cpu_debug_halt && neighbour_wrap_clock
    && setup_out.count_mode == TCSR_MODE_UP
    && setup_out.count_clock_source == TCSR_SRC_NEIGHBOUR_WRAP
    |=> count_step)
    else $error("neighbour wrap did not step");
endmodule

bind tcsr_timer_control_status_regs tcsr_monitor u_mon (
  .aclk, .aresetn, .neighbour_wrap_clock, .quad_count_tick, .count_step,
  .count_reload, .timer_running, .quad_resolution_x4, .cpu_debug_halt,
  .dma_channel_active, .dma_req_clear, .peer_in, .peer_out, .setup_out
);

/* tb/tcsr_peer_model.sv */
`timescale 1ns/1ps
module tcsr_peer_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench requests
  input wire logic wrap_en,
  input wire tcsr_pkg::tcsr_peer_s cmd_req,
  // Timer side
  input wire tcsr_pkg::tcsr_peer_s peer_out,
  output logic neighbour_wrap_clock,
  output tcsr_pkg::tcsr_peer_s peer_in,
  output int wraps,
  output int starts_seen
);
  import tcsr_pkg::*;
  logic [2:0] div;

  // Wraps come every fifth cycle so that each one is a separate step.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 3'h0;
      neighbour_wrap_clock <= 1'b0;
      wraps <= 0;
    end else begin
      div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
      neighbour_wrap_clock <= wrap_en && div == 3'h0;
      if (wrap_en && div == 3'h0) wraps <= wraps + 1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peer_in <= 3'h0;
      starts_seen <= 0;
    end else begin
      peer_in <= cmd_req;
      if (peer_out.start) starts_seen <= starts_seen + 1;
    end
  end
endmodule

/* tb/tcsr_timer_control_status_regs_tb_top.sv */
`timescale 1ns/1ps
module tcsr_timer_control_status_regs_tb_top;
  import tcsr_pkg::*;
  // ------
  // Signals
  // ------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic timer_input = 1'b0, quad_count_tick = 1'b0;
  logic [3:0] chan_input = 4'h0, chan_mode_off_write = 4'h0;
  logic [3:0] capture_event = 4'h0, capture_edge_falling = 4'h0;
  logic [3:0] capture_queue_nonempty = 4'h0, chan_buffer_pending = 4'h0;
  logic [3:0][1:0] channel_function_select = 8'h00;
  logic counter_wrap = 1'b0, count_dir = 1'b0, top_buffer_valid = 1'b0;
  logic cpu_debug_halt = 1'b0, dma_channel_active = 1'b0, wrap_en = 1'b0;
  logic neighbour_wrap_clock, count_step, count_reload, timer_running;
  logic quad_resolution_x4, dma_req_clear;
  tcsr_peer_s peer_in, peer_out;
  tcsr_peer_s cmd_req = 3'h0;
  tcsr_setup_s setup_out;
  int num_errors = 0, checked = 0, cycles = 0, steps = 0, reloads = 0;
  int wraps, starts_seen;

  tcsr_timer_control_status_regs dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .timer_input, .chan_input,
    .neighbour_wrap_clock, .peer_in, .peer_out, .quad_count_tick,
    .counter_wrap, .count_dir, .top_buffer_valid, .count_step, .count_reload,
    .timer_running, .quad_resolution_x4, .setup_out,
    .channel_function_select, .chan_mode_off_write, .capture_event,
    .capture_edge_falling, .capture_queue_nonempty, .chan_buffer_pending,
    .cpu_debug_halt, .dma_channel_active, .dma_req_clear
  );
  tcsr_peer_model u_peer (
    .aclk, .aresetn, .wrap_en, .cmd_req, .peer_out, .neighbour_wrap_clock,
    .peer_in, .wraps, .starts_seen
  );

  always #2 aclk = ~aclk;

  // The longest scenario is the divide-by-1024 window, well under the limit.
  always @(posedge aclk) begin
    cycles++;
    if (count_step === 1'b1) steps++;
    if (count_reload === 1'b1) reloads++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end

  // ------
  // Shared tasks
  // ------
  task automatic test_done();
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic ta, tw, done;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      done = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!done);
    bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    logic ta, done;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!done);
    rready <= 1'b0;
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask

  task automatic pcmd(input logic [2:0] c);
    @(posedge aclk);
    cmd_req <= c;
    @(posedge aclk);
    cmd_req <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    rd(TCSR_SETUP_OFS, TCSR_SETUP_RESET);
    rd(TCSR_STATUS_OFS, 32'h0);
    rd(12'h100, 32'h0, TCSR_RESP_SLVERR);
    wr(12'h100, 32'hFFFF_FFFF, TCSR_RESP_SLVERR);
    wr(TCSR_SETUP_OFS, 32'hFFFF_FFFF);
    rd(TCSR_SETUP_OFS, TCSR_SETUP_WMASK);
    chk(32'(quad_resolution_x4), 32'h1);
    wr(TCSR_SETUP_OFS, 32'h0);
  endtask

  task automatic t_cmd();
    int s;
    s = starts_seen;
    wr(TCSR_CMD_OFS, 32'h1);
    wr(TCSR_CMD_OFS, 32'h0);
    chk(32'(timer_running), 32'h1);
    chk(starts_seen - s, 32'h1);
    wr(TCSR_SETUP_OFS, 32'h4000);
    wr(TCSR_CMD_OFS, 32'h2);
    wr(TCSR_CMD_OFS, 32'h1);
    repeat (3) @(posedge aclk);
    chk(starts_seen - s, 32'h1);
    wr(TCSR_CMD_OFS, 32'h2);
    chk(32'(timer_running), 32'h0);
    wr(TCSR_SETUP_OFS, 32'h10);
    wr(TCSR_CMD_OFS, 32'h1);
    @(posedge aclk);
    counter_wrap <= 1'b1;
    @(posedge aclk);
    counter_wrap <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(timer_running), 32'h0);
  endtask

  task automatic t_clock_divide_select();
    int cd[3] = '{0, 4, 10};
    int s;
    foreach (cd[i]) begin
      wr(TCSR_SETUP_OFS, 32'(cd[i]) << 24);
      wr(TCSR_CMD_OFS, 32'h1);
      @(negedge aclk);
      s = steps;
      repeat (4 << cd[i]) @(negedge aclk);
      chk(steps - s, 32'h4);
    end
    wr(TCSR_SETUP_OFS, 32'h0);
    cpu_debug_halt <= 1'b1;
    repeat (3) @(negedge aclk);
    s = steps;
    repeat (8) @(negedge aclk);
    chk(steps - s, 32'h0);
    wr(TCSR_SETUP_OFS, 32'h40);
    repeat (3) @(negedge aclk);
    s = steps;
    repeat (8) @(negedge aclk);
    chk(steps - s, 32'h8);
    @(posedge aclk);
    cpu_debug_halt <= 1'b0;
    wr(TCSR_CMD_OFS, 32'h2);
  endtask

  task automatic t_src();
    int s, w;
    wr(TCSR_SETUP_OFS, 32'h0002_0000);
    wr(TCSR_CMD_OFS, 32'h1);
    s = steps;
    w = wraps;
    wrap_en <= 1'b1;
    repeat (40) @(posedge aclk);
    wrap_en <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(steps - s, wraps - w);
    wr(TCSR_SETUP_OFS, 32'h0002_0003);
    s = steps;
    wrap_en <= 1'b1;
    repeat (3) begin
      @(posedge aclk);
      quad_count_tick <= 1'b1;
      @(posedge aclk);
      quad_count_tick <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    wrap_en <= 1'b0;
    chk(steps - s, 32'h3);
    wr(TCSR_CMD_OFS, 32'h2);
  endtask

  // Even passes raise the pin, odd passes lower it; only the field of
  // that edge is set, so a swapped field shows as a wrong action.
  task automatic t_edges();
    int a, r;
    for (int i = 0; i < 8; i++) begin
      a = i / 2;
      wr(TCSR_SETUP_OFS, 32'(a) << ((i % 2) ? 10 : 8));
      wr(TCSR_CMD_OFS, (a == 2) ? 32'h1 : 32'h2);
      r = reloads;
      @(posedge aclk);
      timer_input <= ~timer_input;
      repeat (8) @(posedge aclk);
      chk(32'(timer_running), 32'(a == 1 || a == 3));
      chk(reloads - r, 32'(a == 3));
    end
  endtask

  task automatic t_peer();
    int r;
    wr(TCSR_SETUP_OFS, 32'h8);
    wr(TCSR_CMD_OFS, 32'h2);
    pcmd(3'h1);
    chk(32'(timer_running), 32'h1);
    r = reloads;
    pcmd(3'h4);
    chk(reloads - r, 32'h1);
    pcmd(3'h2);
    chk(32'(timer_running), 32'h0);
    wr(TCSR_SETUP_OFS, 32'h0);
    pcmd(3'h1);
    chk(32'(timer_running), 32'h0);
  endtask

  task automatic t_chan();
    channel_function_select[0] <= TCSR_FN_CAPTURE;
    capture_queue_nonempty <= 4'h1;
    capture_edge_falling <= 4'h1;
    capture_event <= 4'h1;
    @(posedge aclk);
    capture_event <= 4'h0;
    rd(TCSR_STATUS_OFS, 32'h0101_0000);
    channel_function_select[0] <= TCSR_FN_OFF;
    chan_mode_off_write <= 4'h1;
    @(posedge aclk);
    chan_mode_off_write <= 4'h0;
    rd(TCSR_STATUS_OFS, 32'h0);
    channel_function_select[3] <= TCSR_FN_COMPARE;
    chan_buffer_pending <= 4'h8;
    chan_input <= 4'h8;
    count_dir <= 1'b1;
    top_buffer_valid <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(TCSR_STATUS_OFS, 32'h0800_0806);
  endtask

  task automatic t_dma();
    wr(TCSR_SETUP_OFS, 32'h80);
    dma_channel_active <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(32'(dma_req_clear), 32'h1);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_cmd();
    t_clock_divide_select();
    t_src();
    t_edges();
    t_peer();
    t_chan();
    t_dma();
    test_done();
  end
endmodule
